/* File: cpcs_pkg.sv */
// Shared constants and types for the command and serial-mode front end.
// Assumes a 16-bit system bus with byte address and separate byte strobes.
package cpcs_pkg;

    // Register byte offsets.
    localparam logic [11:0] CPCS_OFS_CMD   = 12'h0860;
    localparam logic [11:0] CPCS_OFS_MASK  = 12'h08B2;
    localparam logic [11:0] CPCS_OFS_MODE  = 12'h08B4;

    // Command register field positions (register sits on data bits 15..8).
    localparam int CPCS_CMD_RST   = 7;
    localparam int CPCS_CMD_GCI   = 6;
    localparam int CPCS_CMD_OPC   = 4;
    localparam int CPCS_CMD_RSVD  = 3;
    localparam int CPCS_CMD_CHAN  = 1;
    localparam int CPCS_CMD_FLAG  = 0;

    // Mode register field positions.
    localparam int CPCS_MODE_FORCE = 15;
    localparam int CPCS_MODE_SYNC  = 14;
    localparam int CPCS_MODE_DIAG  = 12;
    localparam int CPCS_MODE_B2R   = 8;
    localparam int CPCS_MODE_B1R   = 6;
    localparam int CPCS_MODE_DR    = 4;
    localparam int CPCS_MODE_MSC3  = 3;
    localparam int CPCS_MODE_CHAN2_DISCONNECT  = 2;
    localparam int CPCS_MODE_MS    = 0;

    // Reset values.
    localparam logic [7:0]  CPCS_CMD_RST_VAL  = 8'h00;
    localparam logic [15:0] CPCS_MODE_RST_VAL = 16'h0000;
    localparam logic [15:0] CPCS_MASK_RST_VAL = 16'h0000;

    // Encodings.
    localparam logic [1:0] CPCS_CHAN_RSVD   = 2'h3;
    localparam logic [1:0] CPCS_CHAN_GCI    = 2'h2;
    localparam logic [1:0] CPCS_MS_GCI      = 2'h3;
    localparam logic [1:0] CPCS_OP_STOP_TX  = 2'h0;
    localparam logic [1:0] CPCS_OP_RESTART  = 2'h1;
    localparam logic [1:0] CPCS_OP_HUNT     = 2'h2;
    localparam logic [1:0] CPCS_OP_RST_BCS  = 2'h3;

    // Length of the software reset pulse to the serial channels, in cycles.
    localparam logic [3:0] CPCS_SRST_CYCLES = 4'h4;

    // Diagnostic modes of the serial interface.
    typedef enum logic [1:0] {
        CPCS_DIAG_NORMAL   = 2'h0,
        CPCS_DIAG_ECHO     = 2'h1,
        CPCS_DIAG_LOOPBACK = 2'h2,
        CPCS_DIAG_LOOPCTL  = 2'h3
    } cpcs_diag_t;

    // One command as handed to the serial channels.
    typedef struct packed {
        logic       gci;
        logic [1:0] opcode;
        logic [1:0] chan;
    } cpcs_cmd_t;

endpackage : cpcs_pkg

/* File: cpcs_top.sv */
// Command register and shared serial interface mode and mask registers.
// Assumes bus inputs are synchronous to clk and that each serial channel
// answers an issued command with a one-cycle done pulse.
`timescale 1ns/100ps
`default_nettype none

// Function
// RULE1: Command register at 0x860, upper byte, channel field.
// RULE2: Software sets pending flag; device clears it.
// RULE3: Software checks flag clear before new command.
// RULE4: Bit 7 software reset, cleared by device.
// RULE5: Bit 6 selects GCI opcode interpretation.
// RULE6: Opcode decodes stop, restart, hunt, reset check.
// RULE7: Software writes reserved bit 3 as zero.
// RULE8: One register set configures all three channels.
// RULE9: Mode bit 15 forces layer-1 transmit low; here only when mode bits 1:0 select GCI.
// RULE10: Mode bit 14 selects sync strobe form.
// RULE11: Mode bits 13:12 select diagnostic mode.
// RULE12: Route fields steer time slots to channels.
// RULE13: Mask register at 0x8B2 selects bearer bits.
// RULE14: Flag stays set until command takes effect; here a reserved-channel command is dropped and its flag cleared.
module cpcs_top
    import cpcs_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic [11:0]       sys_addr,
    input  wire logic [15:0]       sys_wdata,
    input  wire logic              sys_wr,
    input  wire logic              sys_rd,
    input  wire logic              sys_ub,
    input  wire logic              sys_lb,
    output logic      [15:0]       sys_rdata,
    output logic                   cmd_valid,
    output cpcs_cmd_t              cmd_out,
    input  wire logic              cmd_done,
    output logic                   soft_reset,
    input  wire logic              layer1_tx_data_in,
    output logic                   layer1_tx_data_out,
    output logic                   sync_pulse_form,
    output cpcs_diag_t             diag_mode,
    output logic      [1:0]        link_mode,
    output logic      [2:0][2:0]   slot_chan_sel,
    output logic      [15:0]       serial_if_bit_mask
);

    typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_RESET} cpcs_state_t;

    cpcs_state_t state;
    cpcs_state_t next_state;
    logic [7:0]  command_reg;
    logic [7:0]  next_command_reg;
    logic [15:0] serial_if_mode_reg;
    logic [15:0] next_rdata;
    logic [3:0]  srst_cnt;
    logic [3:0]  next_srst_cnt;

    // Map a route field to a one-hot channel select, honouring disconnects.
    function automatic logic [2:0] route_sel(input logic [1:0] route,
                                             input logic chan2_disconnect,
                                             input logic msc3);
        logic [2:0] sel;
        sel = 3'h0;
        unique case (route)
            2'h0: sel = 3'h0;
            2'h1: sel = 3'h1;
            2'h2: sel = chan2_disconnect ? 3'h0 : 3'h2;
            2'h3: sel = msc3 ? 3'h0 : 3'h4;
        endcase
        return sel;
    endfunction : route_sel

    // Address decode; the command byte only moves with the upper strobe.
    wire hit_cmd   = (sys_addr == CPCS_OFS_CMD);  // RULE1
    wire hit_mask  = (sys_addr == CPCS_OFS_MASK); // RULE13
    wire hit_mode  = (sys_addr == CPCS_OFS_MODE);
    wire cmd_write = sys_wr && hit_cmd && sys_ub && (state == ST_IDLE);
    wire pending   = command_reg[CPCS_CMD_FLAG];
    wire is_reset  = command_reg[CPCS_CMD_RST];
    wire chan_bad  = (command_reg[CPCS_CMD_CHAN +: 2] == CPCS_CHAN_RSVD);
    wire reset_end = (srst_cnt == CPCS_SRST_CYCLES - 4'h1);
    wire is_gci_if = (link_mode == CPCS_MS_GCI);

    // Command handed to the channel that the channel field names.
    assign cmd_out.gci    = command_reg[CPCS_CMD_GCI];       // RULE5
    assign cmd_out.opcode = command_reg[CPCS_CMD_OPC +: 2];  // RULE6
    assign cmd_out.chan   = command_reg[CPCS_CMD_CHAN +: 2]; // RULE1
    assign cmd_valid      = (state == ST_ISSUE) && !chan_bad;
    assign soft_reset     = (state == ST_RESET);             // RULE4

    // Shared mode fields; one copy serves every channel.
    assign link_mode          = serial_if_mode_reg[CPCS_MODE_MS +: 2]; // RULE8
    assign sync_pulse_form    = serial_if_mode_reg[CPCS_MODE_SYNC];    // RULE10
    assign diag_mode          = cpcs_diag_t'(serial_if_mode_reg[CPCS_MODE_DIAG +: 2]); // RULE11
    // The force only acts on a GCI link, so other modes are never silenced.
    assign layer1_tx_data_out = (serial_if_mode_reg[CPCS_MODE_FORCE] && is_gci_if)
                                ? 1'b0 : layer1_tx_data_in; // RULE9

    // Time slots D, B1 and B2 in that order, each steered to at most one channel.
    genvar gs;
    generate
        for (gs = 0; gs < 3; gs = gs + 1) begin : g_slot
            localparam int POS = CPCS_MODE_DR + 2 * gs;
            assign slot_chan_sel[gs] = route_sel(serial_if_mode_reg[POS +: 2],
                                                 serial_if_mode_reg[CPCS_MODE_CHAN2_DISCONNECT],
                                                 serial_if_mode_reg[CPCS_MODE_MSC3]); // RULE12
        end
    endgenerate

    // Command sequencer. The flag holds until the channel reports that the command
    // took effect, the command is dropped or its reset pulse ends; only a write in the idle cycle right after a command write can still replace it.
    always_comb begin
        next_state       = state;
        next_command_reg = command_reg;
        next_srst_cnt    = 4'h0;
        unique case (state)
            ST_IDLE: begin
                if (cmd_write) begin
                    // Reserved bit is stored as zero whatever was written.
                    next_command_reg = sys_wdata[15:8] & ~(8'h01 << CPCS_CMD_RSVD); // RULE7
                end else if (pending) begin
                    next_state = is_reset ? ST_RESET : ST_ISSUE; // RULE2
                end
            end
            ST_ISSUE: begin
                // A reserved channel number has no target and is dropped.
                if (cmd_done || chan_bad) begin
                    next_command_reg[CPCS_CMD_FLAG] = 1'b0; // RULE14
                    next_state = ST_IDLE;
                end
            end
            ST_RESET: begin
                next_srst_cnt = srst_cnt + 4'h1;
                if (reset_end) begin
                    next_command_reg[CPCS_CMD_RST]  = 1'b0; // RULE4
                    next_command_reg[CPCS_CMD_FLAG] = 1'b0; // RULE2
                    next_state = ST_IDLE;
                end
            end
        endcase
    end

    // Registered read data; unmapped addresses read as zero.
    assign next_rdata = !sys_rd   ? 16'h0000 :
                        hit_cmd  ? {command_reg, 8'h00} :
                        hit_mask ? serial_if_bit_mask :
                        hit_mode ? serial_if_mode_reg : 16'h0000;

    // State and command register.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state       <= ST_IDLE;
            command_reg <= CPCS_CMD_RST_VAL;
            srst_cnt    <= 4'h0;
            sys_rdata   <= 16'h0000;
        end else begin
            state       <= next_state;
            command_reg <= next_command_reg;
            srst_cnt    <= next_srst_cnt;
            sys_rdata   <= next_rdata;
        end
    end

    // Mode and mask registers, written byte by byte.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            serial_if_mode_reg <= CPCS_MODE_RST_VAL;
            serial_if_bit_mask <= CPCS_MASK_RST_VAL;
        end else if (sys_wr) begin
            if (hit_mode && sys_ub) serial_if_mode_reg[15:8] <= sys_wdata[15:8];
            if (hit_mode && sys_lb) serial_if_mode_reg[7:0]  <= sys_wdata[7:0];
            if (hit_mask && sys_ub) serial_if_bit_mask[15:8] <= sys_wdata[15:8]; // RULE13
            if (hit_mask && sys_lb) serial_if_bit_mask[7:0]  <= sys_wdata[7:0];
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_flag_clear_done: assert property ( // RULE14
        (state == ST_ISSUE) && !cmd_done && !chan_bad |=> command_reg[CPCS_CMD_FLAG])
        else $error("Pending flag cleared before the channel finished.");

    chk_issue_to_idle: assert property ( // RULE2
        cmd_valid && cmd_done |=> (state == ST_IDLE) && !command_reg[CPCS_CMD_FLAG])
        else $error("Pending flag not cleared after command completion.");

    chk_pending_starts: assert property ( // RULE2
        (state == ST_IDLE) && pending && !is_reset && !cmd_write |=> cmd_valid || chan_bad)
        else $error("Pending command was not issued.");

    chk_reset_pulse: assert property ( // RULE4
        $rose(soft_reset) |-> soft_reset[*4] ##1 !soft_reset && !command_reg[CPCS_CMD_RST])
        else $error("Software reset pulse length or bit clear wrong.");

    chk_reserved_zero: assert property ( // RULE7
        !command_reg[CPCS_CMD_RSVD])
        else $error("Reserved command bit is set.");

    chk_cmd_fields: assert property ( // RULE1
        cmd_valid |-> cmd_out.chan != CPCS_CHAN_RSVD
                      && cmd_out.opcode == command_reg[CPCS_CMD_OPC +: 2])
        else $error("Issued command fields do not match the register.");

    chk_force_low: assert property ( // RULE9
        serial_if_mode_reg[CPCS_MODE_FORCE] && is_gci_if |-> !layer1_tx_data_out)
        else $error("Layer-1 transmit not forced low.");

    chk_route_disc: assert property ( // RULE12
        serial_if_mode_reg[CPCS_MODE_CHAN2_DISCONNECT] |-> slot_chan_sel[0][1] == 1'b0
            && slot_chan_sel[1][1] == 1'b0 && slot_chan_sel[2][1] == 1'b0)
        else $error("Disconnected second channel still routed.");

    chk_mask_write: assert property ( // RULE13
        sys_wr && hit_mask && sys_ub && sys_lb |=> serial_if_bit_mask == $past(sys_wdata))
        else $error("Mask register did not take the written word.");

    // A write that lands while a command runs must not disturb its fields.
    chk_busy_fields_hold: assert property ( // RULE14
        (state != ST_IDLE) |=> $stable(command_reg[CPCS_CMD_GCI:CPCS_CMD_CHAN]))
        else $error("Command fields changed while a command was in progress.");

    chk_chan_dropped: assert property ( // RULE1
        (state == ST_ISSUE) && chan_bad |=> (state == ST_IDLE) && !pending)
        else $error("Reserved channel command was not dropped.");

endmodule : cpcs_top

`default_nettype wire

/* File: cp_command_and_serial_mode_tb_top.sv */
// Self-checking bench for the command register and serial mode front end.
// Assumes the bench alone drives every port of the front end, with no channel model.
`timescale 1ns/100ps
`default_nettype none
module cp_command_and_serial_mode_tb_top;
    import cpcs_pkg::*;
    logic              clk = 1'b0, rst_n = 1'b0, sys_wr = 1'b0, sys_rd = 1'b0;
    logic              sys_ub = 1'b0, sys_lb = 1'b0, cmd_done = 1'b0, l1_in = 1'b0;
    logic [11:0]       sys_addr = 12'h000;
    logic [15:0]       sys_wdata = 16'h0000, sys_rdata, bit_mask, m, r, e;
    logic              cmd_valid, soft_reset, l1_out, sync_form, rd_seen = 1'b0, cmd_seen = 1'b0;
    cpcs_cmd_t         cmd_out;
    cpcs_diag_t        diag_mode;
    logic [1:0]        link_mode;
    logic [2:0][2:0]   slot_sel;
    logic [3:0]        s;
    logic [31:0]       rq[$];
    logic [4:0]        cq[$];
    int                mismatches = 0, num_checks = 0, n;
    cpcs_top dut_u (.clk(clk), .rst_n(rst_n), .sys_addr(sys_addr), .sys_wdata(sys_wdata),
        .sys_wr(sys_wr), .sys_rd(sys_rd), .sys_ub(sys_ub), .sys_lb(sys_lb),
        .sys_rdata(sys_rdata), .cmd_valid(cmd_valid), .cmd_out(cmd_out), .cmd_done(cmd_done),
        .soft_reset(soft_reset), .layer1_tx_data_in(l1_in), .layer1_tx_data_out(l1_out),
        .sync_pulse_form(sync_form), .diag_mode(diag_mode), .link_mode(link_mode),
        .slot_chan_sel(slot_sel), .serial_if_bit_mask(bit_mask));
    // Free-running 40 MHz clock.
    always #12.5 clk = ~clk;
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic complete_run;
        if (mismatches == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : complete_run
    task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic ub, lb);
        @(negedge clk);
        sys_addr = a; sys_wdata = d; sys_wr = 1'b1; sys_ub = ub; sys_lb = lb;
        @(negedge clk);
        sys_wr = 1'b0;
    endtask : wr
    // The note carries a mask so that fields left open on readback are ignored.
    task automatic rd(input logic [11:0] a, input logic [15:0] exp, input logic [15:0] msk);
        @(negedge clk);
        sys_addr = a; sys_rd = 1'b1; rq.push_back({msk, exp});
        @(negedge clk);
        sys_rd = 0;
    endtask : rd
    // Each command follows a read that showed the flag clear. A stray overlapping
    // write is then sent while busy; the watcher flags a second offer.
    task automatic issue(input logic [7:0] c);
        cq.push_back({c[6], c[5:4], c[2:1]});
        wr(CPCS_OFS_CMD, {c, 8'h00}, 1'b1, 1'b0);
        for (n = 0; n < 20 && cmd_valid !== 1'b1; n++) @(negedge clk);
        rd(CPCS_OFS_CMD, 16'h0100, 16'h0900);
        wr(CPCS_OFS_CMD, 16'h0100, 1'b1, 1'b0);
        repeat ($urandom_range(3)) @(negedge clk);
        check(cmd_valid, 1'b1);
        check(cmd_out, {c[6], c[5:4], c[2:1]});
        cmd_done = 1'b1;
        @(negedge clk);
        cmd_done = 1'b0;
        rd(CPCS_OFS_CMD, 16'h0000, 16'h0100);
        check(cmd_valid, 1'b0);
    endtask : issue
    // Read data is taken one cycle after its strobe; offers are taken as they rise.
    always @(posedge clk) rd_seen <= sys_rd;
    always @(negedge clk) begin
        if (rd_seen) begin
            e = rq[0][31:16];
            check(sys_rdata & e, 16'(rq.pop_front()));
        end
        if (cmd_valid === 1'b1 && !cmd_seen) begin
            if (cq.size() == 0) check(16'h0001, 16'h0000);
            else check(cmd_out, cq.pop_front());
        end
        cmd_seen = (cmd_valid === 1'b1);
    end
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        complete_run();
    end
    initial begin
        void'($urandom(90192));
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        rd(CPCS_OFS_CMD, 16'h0000, 16'hffff);
        rd(CPCS_OFS_MASK, 16'h0000, 16'hffff);
        rd(CPCS_OFS_MODE, 16'h0000, 16'hffff);
        rd(12'h0862, 16'h0000, 16'hffff);
        r = $urandom;
        wr(CPCS_OFS_MASK, r, 1'b1, 1'b1);
        m = $urandom;
        wr(CPCS_OFS_MASK, m, 1'b0, 1'b1);
        check(bit_mask, {r[15:8], m[7:0]});
        rd(CPCS_OFS_MASK, {r[15:8], m[7:0]}, 16'hffff);
        for (int k = 0; k < 16; k++) begin
            s = k[3:0];
            m = $urandom;
            {m[15], m[13:12], m[9:2]} = {s[3], s[1:0], {3{s[1:0]}}, s[3:2]};
            if (s[2]) m[1:0] = 2'h3;
            wr(CPCS_OFS_MODE, m, 1'b1, 1'b1);
            l1_in = s[0];
            @(negedge clk);
            check(sync_form, m[14]);
            check(diag_mode, m[13:12]);
            check(link_mode, m[1:0]);
            e = (s[1:0] == 2'h1) ? 16'h1 : (s[1:0] == 2'h2 && !m[2]) ? 16'h2 :
                (s[1:0] == 2'h3 && !m[3]) ? 16'h4 : 16'h0;
            for (int j = 0; j < 3; j++) check(slot_sel[j], e);
            check(l1_out, s[0] & ~(m[15] & (m[1:0] == 2'h3)));
            rd(CPCS_OFS_MODE, m, 16'hffff);
        end
        // Every opcode on every real channel, then every opcode as a GCI command.
        for (int k = 0; k < 12; k++) issue({2'b00, 2'(k / 3), 1'($urandom), 2'(k % 3), 1'b1});
        for (int k = 0; k < 4; k++) issue({2'b01, k[1:0], 4'b0101});
        wr(CPCS_OFS_CMD, 16'h0700, 1'b1, 1'b0);
        repeat (4) @(negedge clk);
        rd(CPCS_OFS_CMD, 16'h0000, 16'h0100);
        wr(CPCS_OFS_CMD, 16'h8100, 1'b1, 1'b0);
        for (n = 0; n < 20 && soft_reset !== 1'b1; n++) @(negedge clk);
        for (n = 0; n < 20 && soft_reset === 1'b1; n++) @(negedge clk);
        check(n[15:0], {12'h000, CPCS_SRST_CYCLES});
        rd(CPCS_OFS_CMD, 16'h0000, 16'h8100);
        rd(CPCS_OFS_MODE, m, 16'hffff);
        repeat (4) @(negedge clk);
        complete_run();
    end
endmodule : cp_command_and_serial_mode_tb_top
`default_nettype wire
